// >>> core/tbt_transceiver.sv
// 10 Mb/s twisted-pair transceiver logic: Manchester encoder, squelch,
// carrier, collision and heartbeat, link pulses, jabber, polarity fix.
// Assumes comparator outputs and MII inputs synchronous to clk_i.
// Contract
// (RQ1) Half duplex: tx and rx together give collision
// (RQ2) Full duplex: no collision from both directions
// (RQ3) Jabber is also reported as collision
// (RQ4) Collision held while it lasts, raised at once
// (RQ5) Heartbeat pulse 10 bits, 1 us after frame
// (RQ6) Heartbeat off in full duplex or disabled
// (RQ7) Half duplex: carrier on transmit or receive
// (RQ8) Full duplex: carrier on receive only
// (RQ9) Packet ends after over 150 ns quiet
// (RQ10) Squelch needs three alternating crossings, 150 ns apart
// (RQ11) Idle link pulse 100 ns every 16 ms
// (RQ12) Lost link disables tx, rx, collision; jabber and heartbeat still raise col_o with link down
// (RQ13) Force-link bit keeps link good
// (RQ14) Jabber cuts transmitter after 85 ms active
// (RQ15) Unjab after enable low for 500 ms
// (RQ16) Jabber supervision only in 10 Mb/s mode
// (RQ17) Three inverted pulses latch reversed polarity
// (RQ18) Reversed polarity inverts received signal internally
// (RQ19) Enable high: NRZ to pre-emphasised Manchester
// (RQ20) MAC data valid at transmit clock rise
// (RQ21) Frame ends with a final positive transition
// (RQ22) Lower squelch thresholds once data is valid
// (RQ23) Receive clock runs five bits after carrier
// (RQ24) 10 Mb/s serial, 2.5 MHz nibble clock
//
// Register access over Wishbone and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
module tbt_transceiver #(
    parameter int unsigned LP_PERIOD_CYC = tbt_pkg::LP_PERIOD_CYC,
    parameter int unsigned JABBER_CYC    = tbt_pkg::JABBER_CYC,
    parameter int unsigned UNJAB_CYC     = tbt_pkg::UNJAB_CYC,
    parameter int unsigned LINK_LOSS_CYC = tbt_pkg::LINK_LOSS_CYC
) (
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [3:0]             wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output var  logic [31:0]            wb_dat_o,
    output var  logic                   wb_ack_o,
    output var  logic                   tx_clk_o,
    input  wire logic                   tx_en_i,
    input  wire logic [3:0]             txd_i,
    output var  logic                   crs_o,
    output var  logic                   col_o,
    output var  logic                   rx_clk_o,
    output var  logic                   rx_data_o,
    output var  logic                   rx_low_squelch_o,
    input  wire tbt_pkg::tbt_rx_type    tp_rx_i,
    output var  tbt_pkg::tbt_tx_type    tp_tx_o
);

    localparam int unsigned TW = tbt_pkg::TMR_W;
    localparam logic [TW-1:0] LP_LAST   = TW'(LP_PERIOD_CYC - 1);
    localparam logic [TW-1:0] JAB_LAST  = TW'(JABBER_CYC - 1);
    localparam logic [TW-1:0] UNJ_LAST  = TW'(UNJAB_CYC - 1);
    localparam logic [TW-1:0] LOSS_LAST = TW'(LINK_LOSS_CYC - 1);
    localparam logic [1:0] SQ_LAST  = 2'(tbt_pkg::SQ_WIN_CYC);
    localparam logic [1:0] LPW_LAST = 2'(tbt_pkg::LP_WIDTH_CYC - 1);
    localparam logic [1:0] POL_LAST = 2'(tbt_pkg::POL_COUNT - 1);
    localparam logic [5:0] SQE_ON   = 6'(tbt_pkg::SQE_DELAY_CYC);
    localparam logic [5:0] SQE_OFF  =
        6'(tbt_pkg::SQE_DELAY_CYC + tbt_pkg::SQE_LEN_CYC);
    localparam logic [3:0] RXH_LAST = 4'(tbt_pkg::RX_HOLD_CYC);

    // Squelch window elapsed
    function automatic logic sq_expired(input logic [1:0] t);
        sq_expired = (t == SQ_LAST);
    endfunction

    tbt_pkg::tbt_ctrl_type      ctrl;
    tbt_pkg::tbt_sq_state_type  sq;
    logic [31:0]   stat_word;
    logic          bus_req;
    logic          hit;
    logic          wr_now;
    logic          pol_rev;
    logic          pol_set;
    logic [1:0]    inv_cnt;
    logic          link_ok;
    logic          link_good;
    logic [TW-1:0] loss_t;
    logic          jabbered;
    logic [TW-1:0] jab_t;
    logic [2:0]    div;
    logic [2:0]    next_div;
    logic          sample;
    logic          tx_req;
    logic          tx_on;
    logic          tx_act;
    logic          tail;
    logic [3:0]    nib;
    logic [TW-1:0] lp_t;
    logic          lp_on;
    logic [1:0]    lp_w;
    logic          next_level;
    logic          pos_c;
    logic          neg_c;
    logic          pos_d;
    logic          neg_d;
    logic          norm_pulse;
    logic          inv_pulse;
    logic [1:0]    sq_t;
    logic          rx_act;
    logic [3:0]    rx_hold;
    logic          tx_was;
    logic [5:0]    sqe_t;
    logic          sqe_pulse;
    logic          col_now;

    // Wishbone slave: ack one cycle after request, dropped the next
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign hit     = (wb_adr_i == tbt_pkg::REG_CTRL_STAT_OFF);
    assign wr_now  = bus_req & wb_ack_o & wb_we_i & hit & wb_sel_i[0];

    always_comb begin
        stat_word = '0;
        stat_word[tbt_pkg::FD_BIT]         = ctrl.full_duplex;
        stat_word[tbt_pkg::SQE_DIS_BIT]    = ctrl.sqe_disable_bit;
        stat_word[tbt_pkg::FORCE_LINK_BIT] = ctrl.force_link;
        stat_word[tbt_pkg::POL_BIT]        = pol_rev;
        stat_word[tbt_pkg::LINK_BIT]       = link_good;
        stat_word[tbt_pkg::JAB_BIT]        = jabbered;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
            if (bus_req & ~wb_ack_o) begin
                wb_dat_o <= hit ? stat_word : '0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl <= tbt_pkg::CTRL_RESET;
        end else if (wr_now) begin
            ctrl.full_duplex     <= wb_dat_i[tbt_pkg::FD_BIT];
            ctrl.sqe_disable_bit <= wb_dat_i[tbt_pkg::SQE_DIS_BIT];
            ctrl.force_link      <= wb_dat_i[tbt_pkg::FORCE_LINK_BIT];
        end
    end

    // Polarity: raw pulse edges while the squelch is idle
    assign norm_pulse = tp_rx_i.pos & ~pos_d & (sq == tbt_pkg::SQ_IDLE);
    assign inv_pulse  = tp_rx_i.neg & ~neg_d & ~tp_rx_i.pos
                        & (sq == tbt_pkg::SQ_IDLE);
    assign pol_set    = inv_pulse & (inv_cnt == POL_LAST);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pos_d   <= 1'b0;
            neg_d   <= 1'b0;
            inv_cnt <= 2'h0;
        end else begin
            pos_d <= tp_rx_i.pos;
            neg_d <= tp_rx_i.neg;
            if (norm_pulse | pol_set) begin
                inv_cnt <= 2'h0;
            end else if (inv_pulse) begin
                inv_cnt <= inv_cnt + 2'h1; // see (RQ17)
            end
        end
    end

    // Sticky; a new detection beats a write-one clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pol_rev <= 1'b0;
        end else if (pol_set) begin
            pol_rev <= 1'b1; // see (RQ17)
        end else if (wr_now & wb_dat_i[tbt_pkg::POL_BIT]) begin
            pol_rev <= 1'b0;
        end
    end

    assign pos_c = pol_rev ? tp_rx_i.neg : tp_rx_i.pos; // see (RQ18)
    assign neg_c = pol_rev ? tp_rx_i.pos : tp_rx_i.neg; // see (RQ18)

    // Link integrity
    assign link_good = link_ok | ctrl.force_link; // see (RQ13)

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link_ok <= 1'b0;
            loss_t  <= '0;
        end else if (norm_pulse | inv_pulse | (sq == tbt_pkg::SQ_VALID)) begin
            link_ok <= 1'b1;
            loss_t  <= '0;
        end else if (loss_t == LOSS_LAST) begin
            link_ok <= 1'b0; // see (RQ12)
        end else begin
            loss_t <= loss_t + TW'(1);
        end
    end

    // Smart squelch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sq   <= tbt_pkg::SQ_IDLE;
            sq_t <= 2'h0;
        end else begin
            unique case (sq)
                tbt_pkg::SQ_IDLE: begin
                    sq_t <= 2'h0;
                    if (pos_c) begin
                        sq <= tbt_pkg::SQ_FIRST;
                    end
                end
                tbt_pkg::SQ_FIRST: begin
                    if (neg_c) begin
                        sq   <= tbt_pkg::SQ_OPP; // see (RQ10)
                        sq_t <= 2'h0;
                    end else if (sq_expired(sq_t)) begin
                        sq <= tbt_pkg::SQ_IDLE;
                    end else begin
                        sq_t <= sq_t + 2'h1;
                    end
                end
                tbt_pkg::SQ_OPP: begin
                    if (pos_c) begin
                        sq   <= tbt_pkg::SQ_VALID; // see (RQ10)
                        sq_t <= 2'h0;
                    end else if (sq_expired(sq_t)) begin
                        sq <= tbt_pkg::SQ_IDLE;
                    end else begin
                        sq_t <= sq_t + 2'h1;
                    end
                end
                tbt_pkg::SQ_VALID: begin
                    if (pos_c | neg_c) begin
                        sq_t <= 2'h0;
                    end else if (sq_expired(sq_t)) begin
                        sq <= tbt_pkg::SQ_IDLE; // see (RQ9)
                    end else begin
                        sq_t <= sq_t + 2'h1;
                    end
                end
            endcase
        end
    end

    assign rx_act = (sq == tbt_pkg::SQ_VALID) & link_good; // see (RQ12)

    // Receive clock keeps running after carrier drops
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_hold          <= 4'h0;
            rx_clk_o         <= 1'b0;
            rx_data_o        <= 1'b0;
            rx_low_squelch_o <= 1'b0;
        end else begin
            rx_hold <= rx_act ? RXH_LAST
                     : (rx_hold != 4'h0) ? rx_hold - 4'h1 : 4'h0; // see (RQ23)
            rx_clk_o  <= (rx_act | (rx_hold != 4'h0)) & ~rx_clk_o;
            rx_data_o <= pos_c & rx_act;
            rx_low_squelch_o <= (sq == tbt_pkg::SQ_VALID); // see (RQ22)
        end
    end

    // Nibble clock: 8 cycles per nibble, 2 per bit
    assign next_div = div + 3'h1;
    assign sample   = (div == 3'h7); // tx_clk_o rises at this edge

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div      <= 3'h0;
            tx_clk_o <= 1'b0;
        end else begin
            div      <= next_div;
            tx_clk_o <= ~next_div[2]; // see (RQ24)
        end
    end

    // Jabber applies always: this core is the 10 Mb/s path only
    assign tx_act = tx_on & link_good & ~jabbered; // see (RQ12) (RQ16)

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_req <= 1'b0;
            tx_on  <= 1'b0;
            tail   <= 1'b0;
            nib    <= 4'h0;
        end else if (sample) begin
            tx_req <= tx_en_i; // see (RQ20)
            tx_on  <= tx_en_i & link_good & ~jabbered; // see (RQ19)
            nib    <= txd_i;
            tail   <= tx_act & ~(tx_en_i & link_good & ~jabbered)
                      & ~nib[3]; // see (RQ21)
        end else begin
            tail <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            jabbered <= 1'b0;
            jab_t    <= '0;
        end else if (!jabbered) begin
            if (!tx_req) begin
                jab_t <= '0;
            end else if (jab_t == JAB_LAST) begin
                jabbered <= 1'b1; // see (RQ14)
                jab_t    <= '0;
            end else begin
                jab_t <= jab_t + TW'(1);
            end
        end else if (tx_req) begin
            jab_t <= '0; // see (RQ15)
        end else if (jab_t == UNJ_LAST) begin
            jabbered <= 1'b0; // see (RQ15)
            jab_t    <= '0;
        end else begin
            jab_t <= jab_t + TW'(1);
        end
    end

    // Link pulse timer runs only while the line is idle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lp_t  <= '0;
            lp_on <= 1'b0;
            lp_w  <= 2'h0;
        end else if (tx_act | tail) begin
            lp_t  <= '0;
            lp_on <= 1'b0;
        end else if (lp_on) begin
            lp_on <= (lp_w != LPW_LAST); // see (RQ11)
            lp_w  <= lp_w + 2'h1;
        end else if (lp_t == LP_LAST) begin
            lp_t  <= '0;
            lp_on <= 1'b1; // see (RQ11)
            lp_w  <= 2'h0;
        end else begin
            lp_t <= lp_t + TW'(1);
        end
    end

    // Manchester: first half inverted bit, second half the bit, LSB first
    assign next_level = tx_act ? (nib[div[2:1]] ^ ~div[0]) : 1'b1;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tp_tx_o <= '0;
        end else begin
            tp_tx_o.drive <= tx_act | tail | lp_on;
            tp_tx_o.level <= next_level; // see (RQ19) (RQ21)
            // Emphasise the first half-cell after each transition
            tp_tx_o.emph  <= tx_act & (next_level != tp_tx_o.level);
        end
    end

    // Heartbeat timer from the end of each transmitted frame
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_was <= 1'b0;
            sqe_t  <= SQE_OFF;
        end else begin
            tx_was <= tx_act;
            if (tx_was & ~tx_act) begin
                sqe_t <= 6'h0;
            end else if (sqe_t != SQE_OFF) begin
                sqe_t <= sqe_t + 6'h1;
            end
        end
    end

    assign sqe_pulse = (sqe_t >= SQE_ON) & (sqe_t < SQE_OFF)
                       & ~ctrl.full_duplex & ~ctrl.sqe_disable_bit; // see (RQ5) (RQ6)
    assign col_now   = (~ctrl.full_duplex & tx_act & rx_act) // see (RQ1) (RQ2)
                       | (jabbered & tx_req); // see (RQ3)

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            col_o <= 1'b0;
            crs_o <= 1'b0;
        end else begin
            col_o <= col_now | sqe_pulse; // see (RQ4)
            crs_o <= rx_act | (~ctrl.full_duplex & tx_act); // see (RQ7) (RQ8)
        end
    end

    col_half_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (RQ1)
        (!ctrl.full_duplex && tx_act && rx_act) |=> col_o)
        else $error("half duplex overlap without collision");

    col_full_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (RQ2)
        (ctrl.full_duplex && !(jabbered && tx_req)) |=> !col_o)
        else $error("collision raised in full duplex");

    col_jab_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (RQ3)
        (jabbered && tx_req) |=> col_o)
        else $error("jabber not reported as collision");

    crs_half_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (RQ7)
        (!ctrl.full_duplex && tx_act) |=> crs_o)
        else $error("carrier missing during half duplex transmit");

    crs_full_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (RQ8)
        (ctrl.full_duplex && !rx_act) |=> !crs_o)
        else $error("carrier from own transmit in full duplex");

    sq_end_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (RQ9)
        (sq == tbt_pkg::SQ_VALID && !pos_c && !neg_c)[*4]
        |=> sq == tbt_pkg::SQ_IDLE)
        else $error("end of packet not taken after quiet gap");

    sq_valid_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (RQ10)
        (sq == tbt_pkg::SQ_VALID && $past(sq) != tbt_pkg::SQ_VALID)
        |-> ($past(sq) == tbt_pkg::SQ_OPP && $past(pos_c)))
        else $error("valid data without full squelch sequence");

    lp_width_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (RQ11)
        ($rose(lp_on) && !tx_act && !tail) |-> lp_on[*2] ##1 !lp_on)
        else $error("link pulse not two cycles wide");

    link_off_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (RQ12)
        !link_good |-> (!tx_act && !rx_act))
        else $error("traffic active with link down");

    jab_cut_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (RQ14)
        (!jabbered && tx_req && jab_t == JAB_LAST) |=> (jabbered && !tx_act))
        else $error("jabber did not cut the transmitter");

    pol_fix_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (RQ18)
        $rose(pol_rev) |-> (pos_c == tp_rx_i.neg && $past(inv_pulse)))
        else $error("polarity not corrected after detection");

    tx_end_a: assert property (@(posedge clk_i) disable iff (rst_i) // see (RQ21)
        tail |=> (tp_tx_o.drive && tp_tx_o.level))
        else $error("frame end without final high level");

endmodule

// >>> core/tbt_pkg.sv
// Constants and carrier types for the 10 Mb/s twisted-pair transceiver core.
// Assumes a single 20 MHz system clock and a classic Wishbone register bus.
package tbt_pkg;

    // System clock
    localparam int unsigned CLK_HZ  = 20_000_000;
    localparam int unsigned CLK_KHZ = CLK_HZ / 1000;

    // Times in their own units
    localparam int unsigned BIT_NS        = 100;
    localparam int unsigned SQ_WIN_NS     = 150;
    localparam int unsigned LP_WIDTH_NS   = 100;
    localparam int unsigned SQE_DELAY_NS  = 1000;
    localparam int unsigned SQE_BITS      = 10;
    localparam int unsigned RX_HOLD_BITS  = 5;
    localparam int unsigned LP_PERIOD_MS  = 16;
    localparam int unsigned JABBER_MS     = 85;
    localparam int unsigned UNJAB_MS      = 500;
    localparam int unsigned LINK_LOSS_MS  = 100;
    localparam int unsigned POL_COUNT     = 3;

    // Cycle counts; shortest times round down
    localparam int unsigned BIT_CYC       = BIT_NS * CLK_KHZ / 1_000_000;
    localparam int unsigned SQ_WIN_CYC    = SQ_WIN_NS * CLK_KHZ / 1_000_000;
    localparam int unsigned LP_WIDTH_CYC  = LP_WIDTH_NS * CLK_KHZ / 1_000_000;
    localparam int unsigned SQE_DELAY_CYC = SQE_DELAY_NS * CLK_KHZ / 1_000_000;
    localparam int unsigned SQE_LEN_CYC   = SQE_BITS * BIT_CYC;
    localparam int unsigned RX_HOLD_CYC   = RX_HOLD_BITS * BIT_CYC;
    localparam int unsigned LP_PERIOD_CYC = LP_PERIOD_MS * CLK_KHZ;
    localparam int unsigned JABBER_CYC    = JABBER_MS * CLK_KHZ;
    localparam int unsigned UNJAB_CYC     = UNJAB_MS * CLK_KHZ;
    localparam int unsigned LINK_LOSS_CYC = LINK_LOSS_MS * CLK_KHZ;

    // Timer and bus widths
    localparam int unsigned TMR_W  = 24;
    localparam int unsigned ADDR_W = 4;

    // Register map
    localparam logic [ADDR_W-1:0] REG_CTRL_STAT_OFF = 4'h0;
    localparam int unsigned FD_BIT         = 0;
    localparam int unsigned SQE_DIS_BIT    = 1;
    localparam int unsigned FORCE_LINK_BIT = 2;
    localparam int unsigned POL_BIT        = 4;
    localparam int unsigned LINK_BIT       = 5;
    localparam int unsigned JAB_BIT        = 6;
    localparam logic [2:0]  CTRL_RESET     = 3'h0;

    typedef struct packed {
        logic force_link;
        logic sqe_disable_bit;
        logic full_duplex;
    } tbt_ctrl_type;

    typedef struct packed {
        logic drive;
        logic level;
        logic emph;
    } tbt_tx_type;

    typedef struct packed {
        logic pos;
        logic neg;
    } tbt_rx_type;

    typedef enum logic [1:0] {
        SQ_IDLE,
        SQ_FIRST,
        SQ_OPP,
        SQ_VALID
    } tbt_sq_state_type;

endpackage

// >>> testbench/tbt_partner.sv
// Remote twisted-pair station model: drives the squelch comparator outputs.
// Assumes tasks are called just after a rising edge of clk_i.
`timescale 1ns/10ps
module tbt_partner (
    input  wire logic                clk_i,
    output var  tbt_pkg::tbt_rx_type tp_rx_o
);
    initial tp_rx_o = '0;
    // Normal pulse on pos, inverted pulse on neg alone
    task automatic link_pulse(input logic inv);
        tp_rx_o <= inv ? 2'h1 : 2'h2;
        repeat (2) @(posedge clk_i);
        tp_rx_o <= '0;
        repeat (20) @(posedge clk_i);
    endtask
    // One crossing per half-bit, alternating polarity
    task automatic frame(input int n);
        for (int i = 0; i < n; i++) begin
            tp_rx_o <= i[0] ? 2'h1 : 2'h2;
            @(posedge clk_i);
        end
        tp_rx_o <= '0;
    endtask
endmodule

// >>> testbench/tbt_transceiver_bench.sv
// Self-checking bench for the transceiver core: register rows, transmit
// modes, collision, receive, link, polarity and jabber.
// Assumes the remote station model drives the receive comparators.
`timescale 1ns/10ps
module tbt_transceiver_bench;
    typedef struct packed {
        logic [3:0]  adr;
        logic [31:0] wd;
        logic [31:0] rd;
    } tbt_row_type;
    localparam tbt_row_type ROWS [5] = '{
        '{4'h0, 32'h0000_0003, 32'h0000_0003},
        '{4'h4, 32'hFFFF_FFFF, 32'h0000_0000},
        '{4'h0, 32'hFFFF_FFF8, 32'h0000_0000},
        '{4'h0, 32'h0000_0002, 32'h0000_0002},
        '{4'hC, 32'h0000_0001, 32'h0000_0000}};
    // Transmit rows: {crs, col, ctrl}
    localparam logic [4:0] TXM [3] = '{5'h1C, 5'h16, 5'h05};
    logic                clk_i = 1'b0;
    logic                rst_i = 1'b1;
    logic                cyc   = 1'b0;
    logic                stb   = 1'b0;
    logic                we    = 1'b0;
    logic                tx_en = 1'b0;
    logic [3:0]          adr   = 4'h0;
    logic [3:0]          txd   = 4'h5;
    logic [31:0]         wdat  = 32'h0;
    logic [3:0]          sel   = 4'hF;
    logic [31:0]         rdat;
    logic [31:0]         q;
    logic                ack, txc, crs, col, rxc, rxd, lsq, lv;
    tbt_pkg::tbt_rx_type rx;
    tbt_pkg::tbt_tx_type tx;
    int                  failures = 0;
    int                  total_checks = 0;
    logic                cs, ks;

    always #25 clk_i = ~clk_i;

    tbt_transceiver #(.LP_PERIOD_CYC(50), .JABBER_CYC(200),
                      .UNJAB_CYC(300), .LINK_LOSS_CYC(400)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .tx_clk_o(txc), .tx_en_i(tx_en),
        .txd_i(txd), .crs_o(crs), .col_o(col), .rx_clk_o(rxc),
        .rx_data_o(rxd), .rx_low_squelch_o(lsq), .tp_rx_i(rx),
        .tp_tx_o(tx));
    tbt_partner peer_u (.clk_i(clk_i), .tp_rx_o(rx));

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Classic cycle; waits for ack, takes data at that edge
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
        if (n >= 20) chk("wb ack", 1, 0);
    endtask

    task automatic watch(input int n);
        cs = 1'b0;
        ks = 1'b0;
        repeat (n) begin
            @(posedge clk_i);
            cs |= col;
            ks |= crs;
            if (tx.drive) lv = tx.level;
        end
    endtask

    // Enable rises while the nibble clock is high, so the next rise takes it
    task automatic send(input int nib);
        while (txc !== 1'b1) @(posedge clk_i);
        txd   <= 4'(nib);
        tx_en <= 1'b1;
        repeat (nib * 8) @(posedge clk_i);
        tx_en <= 1'b0;
    endtask

    task automatic report_and_stop;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #(20000 * 50);
        failures++;
        report_and_stop;
    end

    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("col reset", 0, col);
        wb(0, 4'h0, 0);
        chk("ctrl reset", 0, q);
        foreach (ROWS[i]) begin
            wb(1, ROWS[i].adr, ROWS[i].wd);
            wb(0, ROWS[i].adr, 0);
            chk("reg row", ROWS[i].rd, q);
        end
        sel <= 4'h0;
        wb(1, 4'h0, 32'h0000_0003);
        sel <= 4'hF;
        wb(0, 4'h0, 0);
        chk("sel ignored", 32'h0000_0002, q);
        $display("test registers done");
        wb(1, 4'h0, 0);
        fork send(2); watch(40); join
        chk("crs link down", 0, ks);
        peer_u.link_pulse(0);
        wb(0, 4'h0, 0);
        chk("link good", 1, q[5]);
        repeat (450) @(posedge clk_i);
        wb(0, 4'h0, 0);
        chk("link lost", 0, q[5]);
        repeat (3) peer_u.link_pulse(1);
        wb(0, 4'h0, 0);
        chk("polarity", 1, q[4]);
        wb(1, 4'h0, 32'h0000_0010);
        wb(0, 4'h0, 0);
        chk("polarity clear", 0, q[4]);
        $display("test link done");
        foreach (TXM[i]) begin
            wb(1, 4'h0, {29'h0, TXM[i][2:0]});
            fork send(4); watch(110); join
            chk("tx crs", TXM[i][4], ks);
            chk("tx col", TXM[i][3], cs);
            chk("last level", 1, lv);
        end
        $display("test transmit done");
        for (int m = 4; m < 6; m++) begin
            wb(1, 4'h0, m);
            fork
                send(6);
                begin
                    repeat (12) @(posedge clk_i);
                    peer_u.frame(30);
                end
                watch(60);
            join
            chk("overlap col", m == 4, cs);
            chk("overlap crs", 1, ks);
        end
        $display("test collision done");
        fork peer_u.frame(40); watch(40); join
        chk("rx crs", 1, ks);
        repeat (8) @(posedge clk_i);
        chk("rx crs end", 0, crs);
        fork peer_u.link_pulse(0); watch(20); join
        chk("noise crs", 0, ks);
        $display("test receive done");
        wb(1, 4'h0, 32'h0000_0004);
        tx_en <= 1'b1;
        watch(260);
        chk("jabber col", 1, cs);
        chk("jabber drive", 0, tx.drive);
        wb(0, 4'h0, 0);
        chk("jabber bit", 1, q[6]);
        tx_en <= 1'b0;
        repeat (150) @(posedge clk_i);
        wb(0, 4'h0, 0);
        chk("still jabbered", 1, q[6]);
        repeat (200) @(posedge clk_i);
        wb(0, 4'h0, 0);
        chk("unjabbed", 0, q[6]);
        $display("test jabber done");
        report_and_stop;
    end
endmodule
